// *** logic/shs_pkg.sv ***
// Package: register map, fields, reset values and timing for standby control
package shs_pkg;
	localparam logic [19:0] SHS_STATUS_CTRL_ADDR = 20'hF0016;
	localparam logic [7:0] SHS_STATUS_CTRL_RST = 8'h00;
	localparam int SHS_OEN_BIT = 1;
	localparam int SHS_LVL_BIT = 0;
	localparam logic [2:0] SHS_SETTLE_SEL_RST = 3'h7;
	localparam int SHS_SETTLE_BASE_LOG2 = 8;
	localparam int SHS_CLK_SEL_W = 2;
	localparam logic [1:0] SHS_CLK_HIGH_XTAL = 2'h0;
	localparam logic [1:0] SHS_CLK_INT_OSC = 2'h1;
	localparam logic [1:0] SHS_CLK_EXT_MAIN = 2'h2;
	localparam logic [1:0] SHS_CLK_SUBSYS = 2'h3;
	typedef enum logic [2:0] {
		SHS_RUN,
		SHS_HALT,
		SHS_STOP,
		SHS_SNOOZE,
		SHS_SETTLE
	} shs_state_t;
endpackage

// *** logic/shs_wake_if.sv ***
// Interface: wake event and release handshake between the sequencer and its helpers
`timescale 1ns/1ps
interface shs_wake_if;
	logic wake_evt;
	logic settle_start;
	logic [2:0] settle_sel;
	logic settle_done;
	modport seq (output wake_evt, output settle_start, output settle_sel, input settle_done);
	modport pin (input wake_evt);
	modport tmr (input settle_start, input settle_sel, output settle_done);
endinterface

// *** logic/shs_settle_timer.sv ***
// Oscillation settle wait counter for stop release
`timescale 1ns/1ps
module shs_settle_timer
	import shs_pkg::*;
#(
	parameter int CNT_W = 19
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	shs_wake_if.tmr wk
);
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;

	// Wait length in clocks for each select code
	function automatic logic [CNT_W-1:0] settle_len(input logic [2:0] sel);
		unique case (sel)
			3'h0: settle_len = CNT_W'(1 << SHS_SETTLE_BASE_LOG2);
			3'h1: settle_len = CNT_W'(1 << 9);
			3'h2: settle_len = CNT_W'(1 << 10);
			3'h3: settle_len = CNT_W'(1 << 11);
			3'h4: settle_len = CNT_W'(1 << 13);
			3'h5: settle_len = CNT_W'(1 << 15);
			3'h6: settle_len = CNT_W'(1 << 17);
			3'h7: settle_len = CNT_W'(1 << 18);
		endcase
	endfunction

	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (wk.settle_start) begin
			cnt_nxt = settle_len(wk.settle_sel) - CNT_W'(1);
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (cnt_r == '0) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign wk.settle_done = done_r;
endmodule

// *** logic/shs_wake_pin.sv ***
// Wake status pin driver with enable and self-inverting level
`timescale 1ns/1ps
module shs_wake_pin
	import shs_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic oen_i,
	input wire logic lvl_i,
	shs_wake_if.pin wk,
	output logic pin_o,
	output logic pin_oe_n_o,
	output logic lvl_flip_o
);
	logic pin_r, pin_nxt;
	logic oe_n_r, oe_n_nxt;
	logic flip_r, flip_nxt;

	always_comb begin
		pin_nxt = pin_r;
		oe_n_nxt = oe_n_r;
		flip_nxt = 1'b0;
		if (wk.wake_evt && oen_i) begin
			pin_nxt = lvl_i;
			oe_n_nxt = 1'b0;
			flip_nxt = 1'b1;
		end
		// Without the enable the pin holds its level
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_r <= 1'b0;
			oe_n_r <= 1'b1;
			flip_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
			oe_n_r <= oe_n_nxt;
			flip_r <= flip_nxt;
		end
	end

	assign pin_o = pin_r;
	assign pin_oe_n_o = oe_n_r;
	assign lvl_flip_o = flip_r;
endmodule

// *** logic/shs_standby_ctrl.sv ***
// Top: halt/stop/snooze sequencer with wake status output control register
`timescale 1ns/1ps
module shs_standby_ctrl
	import shs_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic ARST_N_I,
	// CPU instruction requests
	input wire logic HALT_REQ_I,
	input wire logic STOP_REQ_I,
	input wire logic [SHS_CLK_SEL_W-1:0] CPU_CLK_SEL_I,
	// Interrupt controller
	input wire logic INT_PENDING_I,
	input wire logic INT_ACK_EN_I,
	// Snooze converter trigger and conversion end
	input wire logic SNOOZE_EN_I,
	input wire logic CONV_TRIG_I,
	input wire logic CONV_DONE_I,
	input wire logic CONV_WAKE_I,
	// Register access by CPU
	input wire logic [19:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic REG_BIT_WR_I,
	input wire logic [2:0] REG_BIT_SEL_I,
	input wire logic [7:0] REG_WDATA_I,
	output logic [7:0] REG_RDATA_O,
	input wire logic [2:0] SETTLE_SEL_I,
	// Options and clock select
	input wire logic WDT_EN_OPT_I,
	input wire logic WDT_STBY_OPT_I,
	input wire logic ITMR_CLK_SEL_I,
	input wire logic DMA_ACTIVE_I,
	// Clock and function gating
	output logic CPU_CLK_EN_O,
	output logic MAIN_CLK_EN_O,
	output logic PERIPH_CLK_EN_O,
	output logic LS_OSC_EN_O,
	output logic CLK_MON_EN_O,
	output logic RAM_EN_O,
	output logic GUARD_EN_O,
	output logic HOLD_STATE_O,
	output logic CONV_START_O,
	// CPU resume
	output logic RESUME_O,
	output logic VECTOR_O,
	output logic [2:0] MODE_O,
	// Wake status pin
	output logic WAKE_PIN_O,
	output logic WAKE_PIN_OE_N_O
);
	shs_wake_if wk();

	shs_state_t st_r, st_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic cpu_en_r, cpu_en_nxt;
	logic main_en_r, main_en_nxt;
	logic per_en_r, per_en_nxt;
	logic ls_en_r, ls_en_nxt;
	logic mon_en_r, mon_en_nxt;
	logic ram_en_r, ram_en_nxt;
	logic grd_en_r, grd_en_nxt;
	logic hold_r, hold_nxt;
	logic conv_r, conv_nxt;
	logic resume_r, resume_nxt;
	logic vec_r, vec_nxt;
	logic wake_r, wake_nxt;
	logic start_r, start_nxt;
	logic lvl_flip;
	logic ls_run;
	logic [2:0] sel_r;

	shs_settle_timer u_tmr (
		.clk_i(SYS_CLK_I),
		.arst_n_i(ARST_N_I),
		.wk(wk.tmr)
	);

	shs_wake_pin u_pin (
		.clk_i(SYS_CLK_I),
		.arst_n_i(ARST_N_I),
		.oen_i(ctrl_r[SHS_OEN_BIT]),
		.lvl_i(ctrl_r[SHS_LVL_BIT]),
		.wk(wk.pin),
		.pin_o(WAKE_PIN_O),
		.pin_oe_n_o(WAKE_PIN_OE_N_O),
		.lvl_flip_o(lvl_flip)
	);

	assign wk.wake_evt = wake_r;
	assign wk.settle_start = start_r;
	assign wk.settle_sel = sel_r;

	// Low-speed oscillator keeps running for the interval timer or watchdog
	assign ls_run = ITMR_CLK_SEL_I || (WDT_EN_OPT_I && WDT_STBY_OPT_I);

	// Mode sequencer
	always_comb begin
		st_nxt = st_r;
		resume_nxt = 1'b0;
		vec_nxt = 1'b0;
		wake_nxt = 1'b0;
		start_nxt = 1'b0;
		conv_nxt = 1'b0;
		unique case (st_r)
			SHS_RUN: begin
				if (STOP_REQ_I && CPU_CLK_SEL_I != SHS_CLK_SUBSYS) begin
					if (INT_PENDING_I) begin
						// Pending request sends stop straight to the settle wait
						st_nxt = SHS_SETTLE;
						start_nxt = 1'b1;
					end else begin
						st_nxt = SHS_STOP;
					end
				end else if (HALT_REQ_I) begin
					st_nxt = SHS_HALT;
				end
			end
			SHS_HALT: begin
				if (INT_PENDING_I) begin
					st_nxt = SHS_RUN;
					resume_nxt = 1'b1;
					vec_nxt = INT_ACK_EN_I;
				end
			end
			SHS_STOP: begin
				if (INT_PENDING_I) begin
					st_nxt = SHS_SETTLE;
					start_nxt = 1'b1;
					wake_nxt = 1'b1;
				end else if (SNOOZE_EN_I && CONV_TRIG_I) begin
					st_nxt = SHS_SNOOZE;
					conv_nxt = 1'b1;
				end
			end
			SHS_SNOOZE: begin
				if (CONV_DONE_I) begin
					if (CONV_WAKE_I) begin
						// Snooze back to normal mode
						st_nxt = SHS_RUN;
						resume_nxt = 1'b1;
						vec_nxt = INT_ACK_EN_I;
						wake_nxt = 1'b1;
					end else begin
						st_nxt = SHS_STOP;
					end
				end
			end
			SHS_SETTLE: begin
				// Only the crystal needs the full wait; other clocks resume next cycle
				if (wk.settle_done || CPU_CLK_SEL_I != SHS_CLK_HIGH_XTAL) begin
					st_nxt = SHS_RUN;
					resume_nxt = 1'b1;
					vec_nxt = INT_ACK_EN_I;
				end
			end
		endcase
	end

	// Gating follows the next state so outputs stay registered
	always_comb begin
		cpu_en_nxt = (st_nxt == SHS_RUN);
		main_en_nxt = (st_nxt != SHS_STOP) && (st_nxt != SHS_SNOOZE);
		per_en_nxt = (st_nxt == SHS_RUN) || (st_nxt == SHS_HALT) || (st_nxt == SHS_SNOOZE);
		ls_en_nxt = (st_nxt == SHS_RUN) || ls_run;
		mon_en_nxt = (st_nxt == SHS_RUN) || ((st_nxt == SHS_HALT) && ls_run);
		ram_en_nxt = (st_nxt == SHS_RUN) || ((st_nxt == SHS_HALT) && DMA_ACTIVE_I);
		grd_en_nxt = (st_nxt == SHS_RUN) || ((st_nxt == SHS_HALT) && DMA_ACTIVE_I);
		hold_nxt = (st_nxt != SHS_RUN);
	end

	// Control register: byte or single-bit writes, level self-inverts
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (REG_ADDR_I == SHS_STATUS_CTRL_ADDR) begin
			if (REG_WR_I) begin
				ctrl_nxt = REG_WDATA_I;
			end else if (REG_BIT_WR_I) begin
				ctrl_nxt[REG_BIT_SEL_I] = REG_WDATA_I[0];
			end
		end
		// Hardware inversion wins over a same-cycle software write
		if (lvl_flip) begin
			ctrl_nxt[SHS_LVL_BIT] = ~ctrl_r[SHS_LVL_BIT];
		end
		rdata_nxt = (REG_ADDR_I == SHS_STATUS_CTRL_ADDR) ? ctrl_nxt : 8'h00;
	end

	// Reset ends any mode and restarts from the reset vector
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			st_r <= SHS_RUN;
			ctrl_r <= SHS_STATUS_CTRL_RST;
			rdata_r <= 8'h00;
			sel_r <= SHS_SETTLE_SEL_RST;
			cpu_en_r <= 1'b1;
			main_en_r <= 1'b1;
			per_en_r <= 1'b1;
			ls_en_r <= 1'b1;
			mon_en_r <= 1'b1;
			ram_en_r <= 1'b1;
			grd_en_r <= 1'b1;
			hold_r <= 1'b0;
			conv_r <= 1'b0;
			resume_r <= 1'b0;
			vec_r <= 1'b0;
			wake_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
			sel_r <= SETTLE_SEL_I;
			cpu_en_r <= cpu_en_nxt;
			main_en_r <= main_en_nxt;
			per_en_r <= per_en_nxt;
			ls_en_r <= ls_en_nxt;
			mon_en_r <= mon_en_nxt;
			ram_en_r <= ram_en_nxt;
			grd_en_r <= grd_en_nxt;
			hold_r <= hold_nxt;
			conv_r <= conv_nxt;
			resume_r <= resume_nxt;
			vec_r <= vec_nxt;
			wake_r <= wake_nxt;
			start_r <= start_nxt;
		end
	end

	assign REG_RDATA_O = rdata_r;
	assign CPU_CLK_EN_O = cpu_en_r;
	assign MAIN_CLK_EN_O = main_en_r;
	assign PERIPH_CLK_EN_O = per_en_r;
	assign LS_OSC_EN_O = ls_en_r;
	assign CLK_MON_EN_O = mon_en_r;
	assign RAM_EN_O = ram_en_r;
	assign GUARD_EN_O = grd_en_r;
	assign HOLD_STATE_O = hold_r;
	assign CONV_START_O = conv_r;
	assign RESUME_O = resume_r;
	assign VECTOR_O = vec_r;
	assign MODE_O = st_r;
endmodule

// *** bench/shs_cpu_model.sv ***
// CPU core and interrupt controller model driving instruction strobes and requests
`timescale 1ns/1ps
module shs_cpu_model (
	input wire logic clk_i,
	input wire logic [2:0] mode_i,
	output logic halt_req_o,
	output logic stop_req_o,
	output logic int_pend_o
);
	initial begin
		halt_req_o = 0;
		stop_req_o = 0;
		int_pend_o = 0;
	end
	// One-cycle instruction strobe; functions are stopped by software beforehand
	task automatic instr(input logic st);
		@(negedge clk_i);
		stop_req_o = st;
		halt_req_o = !st;
		@(negedge clk_i);
		stop_req_o = 0;
		halt_req_o = 0;
	endtask
	// Request held until serviced, so a slow release path still sees it
	task automatic irq(input int d);
		repeat (d) @(negedge clk_i);
		int_pend_o = 1;
		repeat (2) @(negedge clk_i);
		for (int i = 0; i < 600 && mode_i != 3'h0; i++) @(negedge clk_i);
		int_pend_o = 0;
	endtask
endmodule

// *** bench/shs_standby_ctrl_checker.sv ***
// Checker: port timing relations of the standby sequencer
`timescale 1ns/1ps
module shs_standby_ctrl_checker (
	input wire logic SYS_CLK_I, ARST_N_I, HALT_REQ_I, STOP_REQ_I, INT_PENDING_I,
	input wire logic INT_ACK_EN_I, SNOOZE_EN_I, CONV_TRIG_I, DMA_ACTIVE_I, WDT_EN_OPT_I,
	input wire logic WDT_STBY_OPT_I, ITMR_CLK_SEL_I, CPU_CLK_EN_O, MAIN_CLK_EN_O,
	input wire logic LS_OSC_EN_O, CLK_MON_EN_O, RAM_EN_O, GUARD_EN_O, HOLD_STATE_O,
	input wire logic CONV_START_O, RESUME_O, VECTOR_O, WAKE_PIN_OE_N_O, PERIPH_CLK_EN_O,
	input wire logic [1:0] CPU_CLK_SEL_I,
	input wire logic [2:0] MODE_O,
	input wire logic [7:0] REG_RDATA_O
);
	wire ls_want = ITMR_CLK_SEL_I || (WDT_EN_OPT_I && WDT_STBY_OPT_I);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	a_halt_entry: assert property (MODE_O == 3'h0 && HALT_REQ_I && !STOP_REQ_I |=> MODE_O == 3'h1)
		else $error("halt not entered");
	a_halt_gating: assert property (MODE_O == 3'h1 |-> !CPU_CLK_EN_O && MAIN_CLK_EN_O && HOLD_STATE_O)
		else $error("halt clock gating wrong");
	a_halt_release: assert property (MODE_O == 3'h1 && INT_PENDING_I |=> MODE_O == 3'h0 && RESUME_O && VECTOR_O == $past(INT_ACK_EN_I))
		else $error("halt release wrong");
	a_stop_subclk: assert property (MODE_O == 3'h0 && STOP_REQ_I && !HALT_REQ_I && CPU_CLK_SEL_I == 2'h3 |=> MODE_O == 3'h0)
		else $error("stop taken on subclock");
	a_stop_fallback: assert property (MODE_O == 3'h0 && STOP_REQ_I && CPU_CLK_SEL_I != 2'h3 && INT_PENDING_I |=> MODE_O == 3'h4)
		else $error("pending stop did not settle");
	a_ram_dma: assert property (MODE_O == 3'h1 && $past(MODE_O) == 3'h1 |-> RAM_EN_O == $past(DMA_ACTIVE_I) && GUARD_EN_O == $past(DMA_ACTIVE_I))
		else $error("ram or guard enable wrong");
	a_ls_osc: assert property (MODE_O == 3'h1 && $past(MODE_O) == 3'h1 |-> LS_OSC_EN_O == $past(ls_want))
		else $error("low-speed osc enable wrong");
	a_clk_mon: assert property (MODE_O == 3'h1 && !LS_OSC_EN_O |-> !CLK_MON_EN_O)
		else $error("clock monitor without osc");
	a_snooze_conv: assert property (MODE_O == 3'h2 && SNOOZE_EN_I && CONV_TRIG_I && !INT_PENDING_I |=> MODE_O == 3'h3 ##[0:1] CONV_START_O)
		else $error("snooze conversion not started");
	// Second reset edge onward: the first edge may still see power-up unknowns
	a_reset_clear: assert property (disable iff (1'b0) !ARST_N_I && $past(!ARST_N_I)
		|-> MODE_O == 3'h0 && REG_RDATA_O == 8'h00 && WAKE_PIN_OE_N_O)
		else $error("reset state wrong");
	a_periph_halt: assert property (MODE_O == 3'h1 || MODE_O == 3'h3 |-> PERIPH_CLK_EN_O)
		else $error("peripheral clock stopped in halt or snooze");
	c_halt_release: cover property (MODE_O == 3'h1 && INT_PENDING_I);
	c_stop_settle: cover property (MODE_O == 3'h4 ##1 MODE_O == 3'h0);
	c_snooze: cover property (CONV_START_O);
endmodule
bind shs_standby_ctrl shs_standby_ctrl_checker u_chk (.SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I),
	.HALT_REQ_I(HALT_REQ_I), .STOP_REQ_I(STOP_REQ_I), .INT_PENDING_I(INT_PENDING_I),
	.INT_ACK_EN_I(INT_ACK_EN_I), .SNOOZE_EN_I(SNOOZE_EN_I), .CONV_TRIG_I(CONV_TRIG_I),
	.DMA_ACTIVE_I(DMA_ACTIVE_I), .WDT_EN_OPT_I(WDT_EN_OPT_I), .WDT_STBY_OPT_I(WDT_STBY_OPT_I),
	.ITMR_CLK_SEL_I(ITMR_CLK_SEL_I), .CPU_CLK_EN_O(CPU_CLK_EN_O), .MAIN_CLK_EN_O(MAIN_CLK_EN_O),
	.LS_OSC_EN_O(LS_OSC_EN_O), .CLK_MON_EN_O(CLK_MON_EN_O), .RAM_EN_O(RAM_EN_O),
	.GUARD_EN_O(GUARD_EN_O), .HOLD_STATE_O(HOLD_STATE_O), .CONV_START_O(CONV_START_O),
	.RESUME_O(RESUME_O), .VECTOR_O(VECTOR_O), .WAKE_PIN_OE_N_O(WAKE_PIN_OE_N_O),
	.PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
	.CPU_CLK_SEL_I(CPU_CLK_SEL_I), .MODE_O(MODE_O), .REG_RDATA_O(REG_RDATA_O));

// *** bench/tb.sv ***
// Self-checking bench for the standby sequencer
`timescale 1ns/1ps
module tb;
	import shs_pkg::*;
	// Clock starts low without a falling edge at time zero
	logic clk = 1'b0;
	logic rst_n, hreq, sreq, pend, ack, snz, trig, cdone, cwake, wr, bwr, dma, wen, wsb, itm, e;
	logic cpu_en, res, vec, pin, oe_n;
	logic [1:0] csel;
	logic [2:0] bsel, ssel, mode;
	logic [7:0] wd, rd, v;
	logic [19:0] addr;
	int n_fail = 0, n_tests = 0, cyc = 0, seed = 22008, sn = 0;
	logic q[$];
	localparam logic [19:0] A = SHS_STATUS_CTRL_ADDR;
	shs_cpu_model cpu (.clk_i(clk), .mode_i(mode), .halt_req_o(hreq), .stop_req_o(sreq),
		.int_pend_o(pend));
	shs_standby_ctrl dut (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .HALT_REQ_I(hreq), .STOP_REQ_I(sreq),
		.CPU_CLK_SEL_I(csel), .INT_PENDING_I(pend), .INT_ACK_EN_I(ack), .SNOOZE_EN_I(snz),
		.CONV_TRIG_I(trig), .CONV_DONE_I(cdone), .CONV_WAKE_I(cwake), .REG_ADDR_I(addr),
		.REG_WR_I(wr), .REG_BIT_WR_I(bwr), .REG_BIT_SEL_I(bsel), .REG_WDATA_I(wd),
		.REG_RDATA_O(rd), .SETTLE_SEL_I(ssel), .WDT_EN_OPT_I(wen), .WDT_STBY_OPT_I(wsb),
		.ITMR_CLK_SEL_I(itm), .DMA_ACTIVE_I(dma), .CPU_CLK_EN_O(cpu_en), .MAIN_CLK_EN_O(),
		.PERIPH_CLK_EN_O(), .LS_OSC_EN_O(), .CLK_MON_EN_O(), .RAM_EN_O(), .GUARD_EN_O(),
		.HOLD_STATE_O(), .CONV_START_O(), .RESUME_O(res), .VECTOR_O(vec), .MODE_O(mode),
		.WAKE_PIN_O(pin), .WAKE_PIN_OE_N_O(oe_n));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic end_sim();
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		n_tests++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (mode === 3'h4) sn++;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	// Each return to run is matched with the oldest noted vector choice
	always @(posedge clk) if (res === 1'b1) begin
		e = q.size() ? q.pop_front() : 1'bx;
		chk({7'h0, vec}, {7'h0, e});
	end
	task automatic wreg(input logic [19:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = !b;
		bwr = b;
		bsel = s;
		@(negedge clk);
		wr = 0;
		bwr = 0;
	endtask
	task automatic rchk(input logic [19:0] a, input logic [7:0] x);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		chk(rd, x);
	endtask
	task automatic wmode(input logic [2:0] m, input int n);
		for (int i = 0; i < n && mode !== m; i++) @(negedge clk);
		chk({5'h0, mode}, {5'h0, m});
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge clk);
		s = 0;
	endtask
	// One standby round trip; the wake delay varies prompt to slow
	task automatic go(input logic st, input logic [1:0] c, input int d);
		csel = c;
		ack = 1'($random(seed));
		{dma, wen, wsb, itm} = 4'($random(seed));
		q.push_back(ack);
		cpu.instr(st);
		wmode(st ? 3'h2 : 3'h1, 3);
		if (!st) chk({7'h0, cpu_en}, 8'h00);
		cpu.irq(d);
		wmode(3'h0, 400);
		repeat (4) @(negedge clk);
	endtask
	initial begin
		{rst_n, ack, snz, trig, cdone, cwake, wr, bwr, dma, wen, wsb, itm} = '0;
		csel = 1;
		ssel = 0;
		bsel = 0;
		addr = 0;
		wd = 0;
		repeat (3) @(negedge clk);
		rst_n = 1;
		rchk(A, SHS_STATUS_CTRL_RST);
		v = 8'($random(seed));
		wreg(A, v, 0, 0);
		rchk(A, v);
		wreg(A, 8'h01, 1, 3'h7);
		rchk(A, {1'b1, v[6:0]});
		wreg(A + 20'h1, 8'hFF, 0, 0);
		rchk(A + 20'h1, 8'h00);
		wreg(A, 8'h00, 0, 0);
		for (int c = 0; c < 4; c++) go(0, 2'(c), (c * 3) + 1);
		csel = SHS_CLK_SUBSYS;
		cpu.instr(1);
		@(negedge clk);
		chk({5'h0, mode}, 8'h00);
		csel = SHS_CLK_INT_OSC;
		q.push_back(ack);
		fork
			cpu.instr(1);
			cpu.irq(0);
		join
		wmode(3'h0, 3);
		go(1, SHS_CLK_INT_OSC, 3);
		chk({6'h0, pin, oe_n}, 8'h01);
		wreg(A, 8'h02, 0, 0);
		go(1, SHS_CLK_EXT_MAIN, 6);
		chk({6'h0, pin, oe_n}, 8'h00);
		rchk(A, 8'h03);
		sn = 0;
		go(1, SHS_CLK_HIGH_XTAL, 2);
		chk({6'h0, pin, oe_n}, 8'h02);
		chk(8'(sn >= 256 && sn < 266), 8'h01);
		rchk(A, 8'h02);
		snz = 1;
		q.push_back(ack);
		cpu.instr(1);
		wmode(3'h2, 3);
		pulse(trig);
		wmode(3'h3, 3);
		pulse(cdone);
		wmode(3'h2, 3);
		pulse(trig);
		wmode(3'h3, 3);
		cwake = 1;
		pulse(cdone);
		wmode(3'h0, 3);
		repeat (4) @(negedge clk);
		chk({6'h0, pin, oe_n}, 8'h00);
		// Low-speed osc off so the monitor gating is seen in halt
		{wen, itm} = 2'h0;
		cpu.instr(0);
		wmode(3'h1, 3);
		repeat (2) @(negedge clk);
		rst_n = 0;
		repeat (2) @(negedge clk);
		chk({5'h0, mode}, 8'h00);
		chk({7'h0, cpu_en}, 8'h01);
		rst_n = 1;
		rchk(A, 8'h00);
		chk(8'(q.size()), 8'h00);
		end_sim();
	end
endmodule
